// file: rtl/sdram_pkg.sv
package sdram_pkg;

   // =========================================================
   // Array organisation (16-bit variant)
   localparam int BANKS   = 4;
   localparam int BANK_W  = 2;
   localparam int ROW_W   = 12;
   localparam int COL_W   = 9;
   localparam int DQ_W    = 16;
   localparam int DQM_W   = 2;
   localparam int BYTE_W  = 8;
   localparam int ADDR_W  = BANK_W + ROW_W + COL_W;
   localparam int COL_X4  = 2048;
   localparam int COL_X8  = 1024;
   localparam int COL_X16 = 512;

   // =========================================================
   // Commands as {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n}
   localparam logic [3:0] CMD_LMR = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WR  = 4'h4;
   localparam logic [3:0] CMD_RD  = 4'h5;
   localparam logic [3:0] CMD_BST = 4'h6;
   localparam logic [3:0] CMD_NOP = 4'h7;

   // =========================================================
   // Mode word fields on the address bus
   localparam int         MR_BL_LSB  = 0;
   localparam int         MR_BT_BIT  = 3;
   localparam int         MR_LAT_LSB = 4;
   localparam int         AP_BIT     = 10;
   localparam logic [2:0] BL_FULL    = 3'h7;
   localparam logic [1:0] LAT_LONG   = 2'h3;
   localparam logic [ROW_W-1:0] MODE_INIT = 12'h020;

   // =========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_RP_NS       = 20;
   localparam int T_RCD_NS      = 20;
   localparam int T_RFC_NS      = 66;
   localparam int T_INIT_NS     = 100000;
   localparam int REF_PERIOD_MS = 16;
   localparam int REF_ROWS      = 4096;
   localparam int NS_PER_MS     = 1000000;
   localparam int RP_CYC   = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RCD_CYC  = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RFC_CYC  = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INIT_CYC = (T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REFI_CYC = (REF_PERIOD_MS * NS_PER_MS / REF_ROWS) / CLK_PERIOD_NS;
   localparam int WR_CYC   = 2;
   localparam int MRD_CYC  = 2;
   localparam int TMR_W    = 13;

endpackage

// file: rtl/sdram_if.sv
`timescale 1ns/10ps
interface sdram_if;
   import sdram_pkg::*;

   logic              cke;
   logic              chip_select_n;
   logic              row_strobe_n;
   logic              col_strobe_n;
   logic              write_enable_n;
   logic              bank_select_low;
   logic              bank_select_high;
   logic [ROW_W-1:0]  row_column_address_bus;
   logic [DQM_W-1:0]  dqm;
   logic [DQ_W-1:0]   ctl_dq;
   logic              ctl_dq_oe_n;
   logic [DQ_W-1:0]   mem_dq;
   logic              mem_dq_oe_n;
   wire  [DQ_W-1:0]   dq;

   // =========================================================
   // Shared data wire
   assign dq = !ctl_dq_oe_n ? ctl_dq : mem_dq;

   modport ctrl (output cke, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n,
                 bank_select_low, bank_select_high, row_column_address_bus, dqm,
                 ctl_dq, ctl_dq_oe_n, input dq);
   modport mem  (input cke, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n,
                 bank_select_low, bank_select_high, row_column_address_bus, dqm, dq,
                 output mem_dq, mem_dq_oe_n);
endinterface

// file: rtl/sdram_device.sv
`timescale 1ns/10ps
// Behaviour
// - All inputs sampled on rising clock only
// - Four banks, 4096 rows, 512 columns
// - Access starts with activate, then read/write
// - Activate takes bank select and row
// - Read/write address gives starting column
// - Burst walks programmed length and order
// - Burst lengths 1,2,4,8,page; terminate command
// - Auto precharge closes row after burst
// - New column accepted every cycle
// - Bank precharges while others keep working
// - Auto refresh and power-down under command
// - Automotive: refresh in 16ms, no self-refresh
// - 4K refreshes per period; column lines
module sdram_device
   import sdram_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   sdram_if.mem     pins
);

   localparam int PRE_W = 2;
   localparam int RFC_W = 2;
   localparam logic [PRE_W-1:0] PRE_RD = PRE_W'(RP_CYC);
   localparam logic [PRE_W-1:0] PRE_WR = PRE_W'(RP_CYC + WR_CYC);
   localparam logic [RFC_W-1:0] RFC_LD = RFC_W'(RFC_CYC);
   localparam logic [COL_W-1:0] COL_ALL = '1;

   typedef struct packed {
      logic [2:0]                     bl;
      logic                           bt;
      logic [1:0]                     lat;
      logic [BANKS-1:0]               open;
      logic [BANKS-1:0][ROW_W-1:0]    row;
      logic [BANKS-1:0][PRE_W-1:0]    pre;
      logic [RFC_W-1:0]               rfc;
      logic                           bst;
      logic                           bwr;
      logic                           bap;
      logic [BANK_W-1:0]              bbank;
      logic [COL_W-1:0]               bcol;
      logic [COL_W-1:0]               bcnt;
      logic [1:0]                     pv;
      logic [1:0][ADDR_W-1:0]         pa;
      logic [DQ_W-1:0]                dq;
      logic                           oe;
   } dev_s;

   dev_s                s_q;
   dev_s                s_d;
   logic [DQ_W-1:0]     mem [0:(1 << ADDR_W) - 1];
   logic [3:0]          cmd;
   logic [BANK_W-1:0]   ba;
   logic [ROW_W-1:0]    a;
   logic                start;
   logic                iss_v;
   logic                iss_wr;
   logic                iss_ap;
   logic [BANK_W-1:0]   iss_bank;
   logic [COL_W-1:0]    iss_base;
   logic [COL_W-1:0]    iss_n;
   logic [COL_W-1:0]    iss_col;
   logic [COL_W-1:0]    mask;
   logic [ADDR_W-1:0]   iss_addr;
   logic                lat_idx;

   assign cmd = {pins.chip_select_n, pins.row_strobe_n, pins.col_strobe_n, pins.write_enable_n};
   assign ba  = {pins.bank_select_high, pins.bank_select_low};
   assign a   = pins.row_column_address_bus;

   // =========================================================
   // Column generator
   always_comb begin
      mask = (s_q.bl == BL_FULL) ? COL_ALL : COL_W'((1 << s_q.bl[1:0]) - 1);
      start = ((cmd == CMD_RD) || (cmd == CMD_WR)) && s_q.open[ba] && (s_q.rfc == '0);
      iss_v    = start || s_q.bst;
      iss_wr   = start ? (cmd == CMD_WR) : s_q.bwr;
      iss_ap   = start ? a[AP_BIT] : s_q.bap;
      iss_bank = start ? ba : s_q.bbank;
      iss_base = start ? a[COL_W-1:0] : s_q.bcol;
      iss_n    = start ? '0 : s_q.bcnt;
      if (s_q.bt && (s_q.bl != BL_FULL)) begin
         iss_col = (iss_base & ~mask) | ((iss_base ^ iss_n) & mask);
      end else begin
         iss_col = (iss_base & ~mask) | (COL_W'(iss_base + iss_n) & mask);
      end
      iss_addr = {iss_bank, s_q.row[iss_bank], iss_col};
   end

   // =========================================================
   // Command decode and burst state
   always_comb begin
      s_d = s_q;
      for (int b = 0; b < BANKS; b++) begin
         if (s_q.pre[b] != '0) begin
            s_d.pre[b] = s_q.pre[b] - 1'b1;
         end
      end
      if (s_q.rfc != '0) begin
         s_d.rfc = s_q.rfc - 1'b1;
      end
      s_d.pv = {s_q.pv[0], 1'b0};
      s_d.pa = {s_q.pa[0], ADDR_W'(0)};
      lat_idx = (s_q.lat == LAT_LONG);
      s_d.oe = s_q.pv[lat_idx];
      s_d.dq = mem[s_q.pa[lat_idx]];
      if (start) begin
         s_d.bst   = 1'b1;
         s_d.bwr   = iss_wr;
         s_d.bap   = iss_ap;
         s_d.bbank = iss_bank;
         s_d.bcol  = iss_base;
      end
      if (iss_v) begin
         s_d.bcnt = iss_n + 1'b1;
         if (!iss_wr) begin
            s_d.pv[0] = 1'b1;
            s_d.pa[0] = iss_addr;
         end
         if (iss_n == mask) begin
            s_d.bst = 1'b0;
            if (iss_ap) begin
               s_d.open[iss_bank] = 1'b0;
               s_d.pre[iss_bank]  = iss_wr ? PRE_WR : PRE_RD;
            end
         end
      end
      case (cmd)
         CMD_BST: begin
            s_d.bst = 1'b0;
         end
         CMD_PRE: begin
            for (int b = 0; b < BANKS; b++) begin
               if (a[AP_BIT] || (BANK_W'(b) == ba)) begin
                  s_d.open[b] = 1'b0;
                  s_d.pre[b]  = PRE_RD;
                  if (s_q.bst && (s_q.bbank == BANK_W'(b))) begin
                     s_d.bst = 1'b0;
                  end
               end
            end
         end
         CMD_ACT: begin
            if (!s_q.open[ba] && (s_q.pre[ba] == '0) && (s_q.rfc == '0)) begin
               s_d.open[ba] = 1'b1;
               s_d.row[ba]  = a;
            end
         end
         CMD_REF: begin
            if (s_q.open == '0) begin
               s_d.rfc = RFC_LD;
            end
         end
         CMD_LMR: begin
            if ((s_q.open == '0) && !s_q.bst) begin
               s_d.bl  = a[MR_BL_LSB +: 3];
               s_d.bt  = a[MR_BT_BIT];
               s_d.lat = a[MR_LAT_LSB +: 2];
            end
         end
         default: begin
         end
      endcase
   end

   // =========================================================
   // State register; low clock enable is power-down
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_q <= '0;
      end else if (pins.cke) begin
         s_q <= s_d;
      end
   end

   // =========================================================
   // Array write with byte masks
   always_ff @(posedge mclk) begin
      if (pins.cke && iss_v && iss_wr) begin
         for (int i = 0; i < DQM_W; i++) begin
            if (!pins.dqm[i]) begin
               mem[iss_addr][i*BYTE_W +: BYTE_W] <= pins.dq[i*BYTE_W +: BYTE_W];
            end
         end
      end
   end

   assign pins.mem_dq      = s_q.dq;
   assign pins.mem_dq_oe_n = ~s_q.oe;

endmodule

// file: rtl/sdram_controller.sv
`timescale 1ns/10ps
module sdram_controller
   import sdram_pkg::*;
(
   input  wire logic                mclk,
   input  wire logic                reset,
   input  wire logic                clk_en,
   input  wire logic                req_valid,
   input  wire logic                req_write,
   input  wire logic [BANK_W-1:0]   req_bank,
   input  wire logic [ROW_W-1:0]    req_row,
   input  wire logic [COL_W-1:0]    req_col,
   input  wire logic [DQ_W-1:0]     req_wdata,
   input  wire logic                pd_req,
   output logic                     req_ready,
   output logic [DQ_W-1:0]          rd_data,
   output logic                     rd_valid,
   sdram_if.ctrl                    pins
);

   typedef enum logic [3:0] {ST_INIT, ST_PALL, ST_REF1, ST_REF2, ST_LMR, ST_IDLE,
                             ST_REF, ST_ACT, ST_RW, ST_DATA, ST_REC} st_e;

   localparam logic [TMR_W-1:0] TM_INIT = TMR_W'(INIT_CYC);
   localparam logic [TMR_W-1:0] TM_RP   = TMR_W'(RP_CYC);
   localparam logic [TMR_W-1:0] TM_RFC  = TMR_W'(RFC_CYC);
   localparam logic [TMR_W-1:0] TM_MRD  = TMR_W'(MRD_CYC);
   localparam logic [TMR_W-1:0] TM_RCD  = TMR_W'(RCD_CYC);
   localparam logic [TMR_W-1:0] TM_LAT  = TMR_W'(2);
   localparam logic [TMR_W-1:0] TM_REC  = TMR_W'(RP_CYC + WR_CYC);
   localparam logic [TMR_W-1:0] TM_REFI = TMR_W'(REFI_CYC);

   typedef struct packed {
      st_e               st;
      logic [TMR_W-1:0]  tmr;
      logic [TMR_W-1:0]  refi;
      logic              ref_due;
      logic              wr;
      logic [BANK_W-1:0] bank;
      logic [ROW_W-1:0]  row;
      logic [COL_W-1:0]  col;
      logic [DQ_W-1:0]   wdata;
      logic [3:0]        cmd;
      logic [ROW_W-1:0]  addr;
      logic              dq_oe;
      logic              cke;
      logic [DQ_W-1:0]   rdata;
      logic              rvalid;
   } ctl_s;

   ctl_s s_q;
   ctl_s s_d;

   always_comb begin
      s_d = s_q;
      s_d.cmd    = CMD_NOP;
      s_d.dq_oe  = 1'b0;
      s_d.rvalid = 1'b0;
      s_d.cke    = 1'b1;
      if (s_q.tmr != '0) begin
         s_d.tmr = s_q.tmr - 1'b1;
      end
      // Refresh interval: 4K refreshes in 16ms
      if (s_q.refi == '0) begin
         s_d.refi = TM_REFI;
      end else begin
         s_d.refi = s_q.refi - 1'b1;
      end
      if (s_q.tmr == '0) begin
         case (s_q.st)
            ST_INIT: begin
               s_d.st   = ST_PALL;
               s_d.cmd  = CMD_PRE;
               s_d.addr = ROW_W'(1 << AP_BIT);
               s_d.tmr  = TM_RP;
            end
            ST_PALL: begin
               s_d.st  = ST_REF1;
               s_d.cmd = CMD_REF;
               s_d.tmr = TM_RFC;
            end
            ST_REF1: begin
               s_d.st  = ST_REF2;
               s_d.cmd = CMD_REF;
               s_d.tmr = TM_RFC;
            end
            ST_REF2: begin
               s_d.st   = ST_LMR;
               s_d.cmd  = CMD_LMR;
               s_d.addr = MODE_INIT;
               s_d.tmr  = TM_MRD;
            end
            ST_LMR: begin
               s_d.st = ST_IDLE;
            end
            ST_IDLE: begin
               if (!s_q.cke) begin
                  s_d.cke = !pd_req;
               end else if (s_q.ref_due) begin
                  s_d.cmd     = CMD_REF;
                  s_d.tmr     = TM_RFC;
                  s_d.ref_due = 1'b0;
               end else if (req_valid) begin
                  s_d.st    = ST_RW;
                  s_d.cmd   = CMD_ACT;
                  s_d.addr  = req_row;
                  s_d.bank  = req_bank;
                  s_d.wr    = req_write;
                  s_d.col   = req_col;
                  s_d.wdata = req_wdata;
                  s_d.tmr   = TM_RCD - 1'b1;
               end else begin
                  s_d.cke = !pd_req;
               end
            end
            ST_RW: begin
               s_d.cmd   = s_q.wr ? CMD_WR : CMD_RD;
               s_d.addr  = ROW_W'(s_q.col) | ROW_W'(1 << AP_BIT);
               s_d.dq_oe = s_q.wr;
               s_d.st    = s_q.wr ? ST_REC : ST_DATA;
               s_d.tmr   = s_q.wr ? TM_REC : TM_LAT;
            end
            ST_DATA: begin
               s_d.rdata  = pins.dq;
               s_d.rvalid = 1'b1;
               s_d.st     = ST_REC;
               s_d.tmr    = TM_RP;
            end
            ST_REC: begin
               s_d.st = ST_IDLE;
            end
            default: begin
               s_d.st = ST_INIT;
            end
         endcase
      end
      // Set wins over the clear taken with the refresh command
      if (s_q.refi == '0) begin
         s_d.ref_due = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         s_q      <= '0;
         s_q.st   <= ST_INIT;
         s_q.tmr  <= TM_INIT;
         s_q.cmd  <= CMD_NOP;
         s_q.cke  <= 1'b1;
         s_q.refi <= TM_REFI;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign req_ready                   = (s_q.st == ST_IDLE) && (s_q.tmr == '0) && s_q.cke && !s_q.ref_due;
   assign rd_data                     = s_q.rdata;
   assign rd_valid                    = s_q.rvalid;
   assign pins.cke                    = s_q.cke;
   assign {pins.chip_select_n, pins.row_strobe_n, pins.col_strobe_n, pins.write_enable_n} = s_q.cmd;
   assign pins.bank_select_low        = s_q.bank[0];
   assign pins.bank_select_high       = s_q.bank[1];
   assign pins.row_column_address_bus = s_q.addr;
   assign pins.dqm                    = '0;
   assign pins.ctl_dq                 = s_q.wdata;
   assign pins.ctl_dq_oe_n            = ~s_q.dq_oe;

endmodule

// file: sim/sdram_link_asserts.sv
`timescale 1ns/10ps
module sdram_link_asserts
   import sdram_pkg::*;
(
   input wire logic              mclk,
   input wire logic              reset,
   input wire logic              cke,
   input wire logic              chip_select_n,
   input wire logic              row_strobe_n,
   input wire logic              col_strobe_n,
   input wire logic              write_enable_n,
   input wire logic              bank_select_low,
   input wire logic              bank_select_high,
   input wire logic [ROW_W-1:0]  row_column_address_bus,
   input wire logic [DQM_W-1:0]  dqm,
   input wire logic [DQ_W-1:0]   ctl_dq,
   input wire logic              ctl_dq_oe_n,
   input wire logic [DQ_W-1:0]   mem_dq,
   input wire logic              mem_dq_oe_n,
   input wire logic [DQ_W-1:0]   dq
);
   localparam int REF_LIMIT = REFI_CYC + 64;
   logic [3:0] cmd;
   logic [1:0] bank;
   logic       is_rd;
   logic       is_wr;
   logic       is_ref;
   logic [8:0] ref_gap_q;
   logic       ref_seen_q;
   assign cmd    = {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n};
   assign bank   = {bank_select_high, bank_select_low};
   assign is_rd  = cmd == CMD_RD;
   assign is_wr  = cmd == CMD_WR;
   assign is_ref = cmd == CMD_REF;
   // =========================================================
   // Cycles since the last refresh, counted while clocked
   always_ff @(posedge mclk) begin
      if (reset) begin
         ref_gap_q  <= '0;
         ref_seen_q <= 1'b0;
      end else if (is_ref) begin
         ref_gap_q  <= '0;
         ref_seen_q <= 1'b1;
      end else if (ref_seen_q && cke && ref_gap_q != 9'h1ff) begin
         ref_gap_q <= ref_gap_q + 9'h001;
      end
   end
   // =========================================================
   // Properties
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   sequence s_act;
      cmd == CMD_ACT;
   endsequence
   sequence s_col;
      is_rd || is_wr;
   endsequence
   sequence s_beat;
      !mem_dq_oe_n ##1 mem_dq_oe_n;
   endsequence
   a_act_then_col: assert property (s_act |=> s_col) else $error("no column command after activate");
   a_bank_held: assert property (s_act |=> bank == $past(bank)) else $error("column bank differs");
   a_auto_pre: assert property (s_col |-> row_column_address_bus[AP_BIT]) else $error("auto precharge off");
   a_read_beat: assert property (is_rd |-> ##2 s_beat) else $error("read beat misplaced");
   a_beat_cause: assert property (!mem_dq_oe_n |-> $past(is_rd, 2)) else $error("data without read");
   a_no_clash: assert property (!(!ctl_dq_oe_n && !mem_dq_oe_n)) else $error("both drive data");
   a_wr_drives: assert property (is_wr |-> !ctl_dq_oe_n && dq == ctl_dq) else $error("write data absent");
   a_ref_quiet: assert property (is_ref |=> (cmd != CMD_ACT) [*2]) else $error("activate during refresh");
   a_pd_idle: assert property (!cke |-> mem_dq_oe_n && ctl_dq_oe_n) else $error("data during power-down");
   a_no_self_ref: assert property (is_ref |-> cke) else $error("self refresh entered");
   a_ref_gap: assert property (ref_gap_q <= REF_LIMIT) else $error("refresh too late");
   c_read: cover property (is_rd ##2 !mem_dq_oe_n);
endmodule

// file: sim/quad_bank_sdram_access_core_tb.sv
`timescale 1ns/10ps
module quad_bank_sdram_access_core_tb
   import sdram_pkg::*;
;
   logic              mclk;
   logic              reset;
   logic              clk_en;
   logic              req_valid;
   logic              req_write;
   logic              pd_req;
   logic [BANK_W-1:0] req_bank;
   logic [ROW_W-1:0]  req_row;
   logic [COL_W-1:0]  req_col;
   logic [DQ_W-1:0]   req_wdata;
   wire               req_ready;
   wire               rd_valid;
   wire  [DQ_W-1:0]   rd_data;
   int                n_errors;
   int                n_checks;
   int                ref_seen;
   sdram_if bus();
   sdram_controller i_sdram_controller (.mclk(mclk), .reset(reset), .clk_en(clk_en), .req_valid(req_valid),
      .req_write(req_write), .req_bank(req_bank), .req_row(req_row), .req_col(req_col), .req_wdata(req_wdata),
      .pd_req(pd_req), .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid), .pins(bus));
   sdram_device i_sdram_device (.mclk(mclk), .reset(reset), .pins(bus));
   sdram_link_asserts i_sdram_link_asserts (.mclk(mclk), .reset(reset), .cke(bus.cke),
      .chip_select_n(bus.chip_select_n), .row_strobe_n(bus.row_strobe_n), .col_strobe_n(bus.col_strobe_n),
      .write_enable_n(bus.write_enable_n), .bank_select_low(bus.bank_select_low),
      .bank_select_high(bus.bank_select_high), .row_column_address_bus(bus.row_column_address_bus),
      .dqm(bus.dqm), .ctl_dq(bus.ctl_dq), .ctl_dq_oe_n(bus.ctl_dq_oe_n), .mem_dq(bus.mem_dq),
      .mem_dq_oe_n(bus.mem_dq_oe_n), .dq(bus.dq));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (!reset && bus.cke && {bus.chip_select_n, bus.row_strobe_n, bus.col_strobe_n, bus.write_enable_n} == CMD_REF)
         ref_seen++;
   end
   // =========================================================
   // Shared tasks
   task check(input string what, input logic [DQ_W-1:0] seen, input logic [DQ_W-1:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task finish_test;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task wait_ready;
      for (int i = 0; i < 6000; i++) begin
         @(negedge mclk);
         if (req_ready === 1'b1)
            return;
      end
      n_errors++;
      $display("Error req_ready expected 1 seen 0");
      finish_test();
   endtask
   task access(input logic wr, input logic [1:0] b, input logic [11:0] r, input logic [8:0] c,
               input logic [15:0] d);
      @(posedge mclk);
      #2;
      {req_valid, req_write, req_bank, req_row, req_col, req_wdata} = {1'b1, wr, b, r, c, d};
      wait_ready();
      @(posedge mclk);
      #2;
      req_valid = 1'b0;
   endtask
   task do_read(input logic [1:0] b, input logic [11:0] r, input logic [8:0] c, input logic [15:0] exp);
      int i;
      access(1'b0, b, r, c, 16'h0000);
      for (i = 0; i < 20 && rd_valid !== 1'b1; i++)
         @(negedge mclk);
      check("rd_valid", {15'h0000, rd_valid}, 16'h0001);
      check("rd_data", rd_data, exp);
      if (i == 20)
         finish_test();
   endtask
   task t_freeze;
      wait_ready();
      @(posedge mclk);
      #2;
      clk_en = 1'b0;
      {req_valid, req_write, req_bank, req_row, req_col} = {1'b1, 1'b0, 2'h0, 12'h000, 9'h000};
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      check("frozen req_ready", {15'h0000, req_ready}, 16'h0001);
      check("frozen rd_valid", {15'h0000, rd_valid}, 16'h0000);
      @(posedge mclk);
      #2;
      req_valid = 1'b0;
      clk_en = 1'b1;
      do_read(2'h0, 12'h000, 9'h000, 16'h1234);
      $display("test freeze done");
   endtask
   // =========================================================
   // Scenarios
   task t_corners;
      access(1'b1, 2'h3, 12'hfff, 9'h1ff, 16'ha5c3);
      access(1'b1, 2'h3, 12'hfff, 9'h1fe, 16'h5a3c);
      access(1'b1, 2'h0, 12'h000, 9'h000, 16'h1234);
      do_read(2'h3, 12'hfff, 9'h1ff, 16'ha5c3);
      do_read(2'h3, 12'hfff, 9'h1fe, 16'h5a3c);
      do_read(2'h0, 12'h000, 9'h000, 16'h1234);
      $display("test corners done");
   endtask
   task t_banks;
      for (int b = 0; b < BANKS; b++)
         access(1'b1, 2'(b), 12'h010 + 12'(b), 9'h020, 16'h1000 + 16'(b));
      access(1'b1, 2'h2, 12'h7ff, 9'h020, 16'hbeef);
      for (int b = 0; b < BANKS; b++)
         do_read(2'(b), 12'h010 + 12'(b), 9'h020, 16'h1000 + 16'(b));
      do_read(2'h2, 12'h7ff, 9'h020, 16'hbeef);
      $display("test banks done");
   endtask
   task t_refresh;
      int r0;
      r0 = ref_seen;
      repeat (400) @(posedge mclk);
      check("refreshes", {15'h0000, (ref_seen - r0) >= 400 / REFI_CYC}, 16'h0001);
      $display("test refresh done");
   endtask
   task t_power_down;
      wait_ready();
      @(posedge mclk);
      #2;
      pd_req = 1'b1;
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      check("cke", {15'h0000, bus.cke}, 16'h0000);
      check("req_ready", {15'h0000, req_ready}, 16'h0000);
      @(posedge mclk);
      #2;
      pd_req = 1'b0;
      wait_ready();
      check("cke", {15'h0000, bus.cke}, 16'h0001);
      do_read(2'h3, 12'hfff, 9'h1ff, 16'ha5c3);
      $display("test power_down done");
   endtask
   initial begin
      {reset, clk_en, req_valid, req_write, pd_req} = 5'b11000;
      {req_bank, req_row, req_col, req_wdata} = '0;
      repeat (2) @(posedge mclk);
      #2;
      reset = 1'b0;
      wait_ready();
      check("cke", {15'h0000, bus.cke}, 16'h0001);
      $display("test init done");
      t_corners();
      t_banks();
      t_refresh();
      t_power_down();
      t_freeze();
      finish_test();
   end
endmodule
